// File: hdl/ctd_defs.svh
// ----------------------------------------------------------------
// constants of the close transition detector
// ----------------------------------------------------------------
// assumes: included by its bare name from package and modules
`ifndef CTD_DEFS_SVH
`define CTD_DEFS_SVH

// core clock rate in Hz
`define CTD_CORE_CLK_HZ 100000000
// reference tick rate in Hz (128 kHz)
`define CTD_TICK_HZ 128000
// core cycles per tick period, rounded down
`define CTD_DIV_CYCLES (`CTD_CORE_CLK_HZ / `CTD_TICK_HZ)
// core cycle of the tick period where the low half starts
`define CTD_DIV_HALF (`CTD_DIV_CYCLES / 2)
// width of the divider count
`define CTD_DIV_W 10
// window counter width, ninth stage is the top bit
`define CTD_WIN_W 9
// ninth counter stage, 256 ticks or 2 ms
`define CTD_WIN_STAGE 8
// reset value of the window counter
`define CTD_WIN_RST 9'h000

`endif

// File: hdl/ctd_pkg.sv
// ----------------------------------------------------------------
// types of the close transition detector
// ----------------------------------------------------------------
// assumes: ctd_defs.svh on the include path
`include "ctd_defs.svh"

package ctd_pkg;
  typedef logic [`CTD_DIV_W-1:0] ctd_div_t;
  typedef logic [`CTD_WIN_W-1:0] ctd_count_t;
endpackage

// File: hdl/ctd_tick_gen.sv
// ----------------------------------------------------------------
// 128 kHz tick generator: rise and fall enables
// ----------------------------------------------------------------
// assumes: synchronous reset copy from the parent, one core clock
`timescale 1ns/1ps
`include "ctd_defs.svh"

module ctd_tick_gen
  import ctd_pkg::*;
(
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i, // reset copy, active low
  output logic rise_en_o, // one-cycle pulse, tick rising edge
  output logic fall_en_o // one-cycle pulse, tick falling edge
);
  import ctd_pkg::*;

  ctd_div_t div_cnt;

  // the tick runs 781 core cycles, 0.03 % fast; harmless for a 2 ms window
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_cnt <= '0;
    else if (div_cnt == ctd_div_t'(`CTD_DIV_CYCLES - 1))
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + ctd_div_t'(1);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rise_en_o <= 1'b0;
      fall_en_o <= 1'b0;
    end
    else
    begin
      rise_en_o <= (div_cnt == ctd_div_t'(`CTD_DIV_CYCLES - 1));
      fall_en_o <= (div_cnt == ctd_div_t'(`CTD_DIV_HALF - 1));
    end
  end

  a_tick_exclusive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(rise_en_o && fall_en_o))
    else $error("tick rise and fall enables coincide");
endmodule

// File: hdl/ctd_close_transition_detector.sv
// ----------------------------------------------------------------
// close transition detector: data transition pulses and 2 ms window
// ----------------------------------------------------------------
// assumes: data_i is the sliced mark/space line, asynchronous;
// close_pulse_o feeds a ratio detector on the same core clock.
//
// Summary of operation
// - registered data copy xor live data flags any transition
// - mismatch is captured into the pulse flop at tick rise
// - in the following low tick half, pulse strobes copy to live data
// - next tick rise drops the pulse; one pulse per transition
// - trailing pulse edge sets window flop, releasing counter reset
// - ninth counter stage sampled half a tick later clears window
// - closed window holds the counter at zero
// - close pulse is transition pulse gated by open window
// - transition inside 2 ms window gives close pulse, else none
`timescale 1ns/1ps
`include "ctd_defs.svh"

module ctd_close_transition_detector
  import ctd_pkg::*;
(
  input wire logic core_clk_i, // 100 MHz core clock
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire logic data_i, // mark/space comparator data line
  output logic transition_pulse_o, // one tick wide per transition
  output logic window_open_o, // 2 ms window running
  output logic close_pulse_o // transition inside open window
);
  import ctd_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // tick enables
  // ----------------------------------------------------------------
  logic rise_en;
  logic fall_en;

  ctd_tick_gen u_tick (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .rise_en_o(rise_en),
    .fall_en_o(fall_en)
  );

  // ----------------------------------------------------------------
  // data input synchroniser
  // ----------------------------------------------------------------
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic data_sync;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      data_sync <= 1'b0;
    end
    else
    begin
      sync_a <= data_i;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (sync_b == sync_c)
        data_sync <= sync_c;
    end
  end

  // ----------------------------------------------------------------
  // transition detector
  // ----------------------------------------------------------------
  logic data_copy_flop;
  logic transition_xor;
  logic transition_pulse_flop;
  logic copy_strobe_nor;

  assign transition_xor = data_sync ^ data_copy_flop;
  // copy is strobed only in the low tick half while the pulse stands
  assign copy_strobe_nor = fall_en && transition_pulse_flop;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      data_copy_flop <= 1'b0;
    else if (copy_strobe_nor)
      data_copy_flop <= data_sync;
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      transition_pulse_flop <= 1'b0;
    else if (rise_en)
      transition_pulse_flop <= transition_xor;
  end

  // ----------------------------------------------------------------
  // two millisecond window
  // ----------------------------------------------------------------
  logic window_flop;
  logic window_terminate_flop;
  ctd_count_t window_counter;
  logic counter_ninth_stage;
  logic pulse_trailing;

  assign counter_ninth_stage = window_counter[`CTD_WIN_STAGE];
  assign pulse_trailing = rise_en && transition_pulse_flop && !transition_xor;

  // set on trailing edge, cleared by terminate
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      window_flop <= 1'b0;
    else if (window_terminate_flop)
      window_flop <= 1'b0;
    else if (pulse_trailing)
      window_flop <= 1'b1;
  end

  // counter held at zero while closed
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      window_counter <= `CTD_WIN_RST;
    else if (!window_flop)
      window_counter <= `CTD_WIN_RST;
    else if (rise_en)
      window_counter <= window_counter + ctd_count_t'(1);
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      window_terminate_flop <= 1'b0;
    else if (fall_en)
      window_terminate_flop <= counter_ninth_stage;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic close_transition_gate;

  assign close_transition_gate = transition_pulse_flop && window_flop;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      transition_pulse_o <= 1'b0;
      window_open_o <= 1'b0;
      close_pulse_o <= 1'b0;
    end
    else
    begin
      transition_pulse_o <= transition_pulse_flop;
      window_open_o <= window_flop;
      close_pulse_o <= close_transition_gate;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_sync_agree: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $changed(data_sync) |-> $past(sync_b) == $past(sync_c))
    else $error("data accepted before two stages agreed");

  a_xor_flags: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $changed(data_sync) && !$past(copy_strobe_nor) && !$past(transition_xor) |-> transition_xor)
    else $error("transition not flagged by mismatch");

  a_pulse_capture: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    rise_en && transition_xor |=> transition_pulse_flop)
    else $error("mismatch not captured at tick rise");

  a_copy_strobe: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    fall_en && transition_pulse_flop |=> data_copy_flop == $past(data_sync))
    else $error("copy not strobed in low tick half");

  a_pulse_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    rise_en && transition_pulse_flop && !transition_xor |=> !transition_pulse_flop)
    else $error("pulse not dropped after mismatch cleared");

  a_window_open: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(transition_pulse_flop) && !$past(window_terminate_flop) |-> window_flop)
    else $error("window not opened on trailing pulse edge");

  a_window_end: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    fall_en && counter_ninth_stage |=> window_terminate_flop ##1 !window_flop)
    else $error("ninth stage did not close the window");

  a_counter_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !window_flop |=> window_counter == `CTD_WIN_RST)
    else $error("counter runs while window closed");

  a_close_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    close_pulse_o == ($past(transition_pulse_flop) && $past(window_flop)))
    else $error("close pulse not the gated transition pulse");

  a_close_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
    !window_open_o |-> !close_pulse_o)
    else $error("close pulse without open window");

  c_transition: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(transition_pulse_o));
  c_window_expire: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $fell(window_open_o));
  c_close_hit: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(close_pulse_o));
endmodule

// File: tb/ctd_ratio_model.sv
// ----------------------------------------------------------------
// ratio detector stand-in: counts close transition pulses
// ----------------------------------------------------------------
// assumes: same core clock and reset as the detector
`timescale 1ns/1ps

module ctd_ratio_model
(
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i, // reset, active low
  input wire logic close_pulse_i, // close transition pulse
  output int close_count_o // close pulses seen
);
  logic prev;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev <= 1'b0;
      close_count_o <= 0;
    end
    else
    begin
      prev <= close_pulse_i;
      // a long pulse counts once, as the real period flag does
      if (close_pulse_i && !prev)
        close_count_o <= close_count_o + 1;
    end
  end
endmodule

// File: tb/ctd_close_transition_detector_tb.sv
// ----------------------------------------------------------------
// self-checking bench of the close transition detector
// ----------------------------------------------------------------
// assumes: fixed 781-cycle tick, no way to shorten the 2 ms window
`timescale 1ns/1ps

module ctd_close_transition_detector_tb;
  import ctd_pkg::*;
  localparam int TICK = 781;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic data_i = 1'b0;
  logic transition_pulse_o;
  logic window_open_o;
  logic close_pulse_o;
  logic prev_pulse = 1'b0;
  logic prev_win = 1'b0;
  int close_count;
  int n_fail = 0;
  int comparisons = 0;
  int n_pulses = 0;
  int pulse_len = 0;
  int win_len = 0;
  bit exp_close_q[$];

  always #5 core_clk_i = ~core_clk_i;

  ctd_close_transition_detector dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .data_i(data_i),
    .transition_pulse_o(transition_pulse_o), .window_open_o(window_open_o), .close_pulse_o(close_pulse_o));
  ctd_ratio_model ratio_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .close_pulse_i(close_pulse_o),
    .close_count_o(close_count));

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic cmp_span(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("unexpected at %0t: %s %0d", $time, what, got);
    end
  endtask

  // ----------------------------------------------------------------
  // output watcher, sampled mid-cycle where outputs are settled
  // ----------------------------------------------------------------
  always @(negedge core_clk_i)
  begin
    if (transition_pulse_o === 1'b1)
      pulse_len++;
    if (window_open_o === 1'b1)
      win_len++;
    if (close_pulse_o !== 1'b0)
      cmp_bit(transition_pulse_o, 1'b1, "close pulse without transition");
    if (transition_pulse_o === 1'b1 && prev_pulse !== 1'b1)
    begin
      if (exp_close_q.size() == 0)
        cmp_bit(1'b1, 1'b0, "pulse without data change");
      else
        cmp_bit(close_pulse_o, exp_close_q.pop_front(), "close pulse level");
    end
    if (transition_pulse_o !== 1'b1 && prev_pulse === 1'b1)
    begin
      cmp_span(pulse_len, TICK, TICK, "transition pulse width");
      pulse_len = 0;
      n_pulses++;
    end
    if (window_open_o === 1'b1 && prev_win !== 1'b1)
      cmp_bit(prev_pulse, 1'b1, "window not opened by pulse end");
    if (window_open_o !== 1'b1 && prev_win === 1'b1)
    begin
      // later pulses must not stretch the window
      cmp_span(win_len, 255 * TICK, 257 * TICK, "window length");
      win_len = 0;
    end
    prev_pulse = transition_pulse_o;
    prev_win = window_open_o;
  end

  // flip the line and wait, bounded, for its pulse to end
  task automatic flip(input bit exp_close);
    int start;
    start = n_pulses;
    exp_close_q.push_back(exp_close);
    @(posedge core_clk_i);
    data_i <= ~data_i;
    for (int i = 0; i < 2000 && n_pulses == start; i++)
      @(posedge core_clk_i);
    cmp_bit(n_pulses != start, 1'b1, "no transition pulse");
  endtask

  task automatic wait_closed();
    for (int i = 0; i < 210000 && window_open_o !== 1'b0; i++)
      @(posedge core_clk_i);
    cmp_bit(window_open_o, 1'b0, "window never closed");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    int gap;
    gap = $urandom(48829);
    // a scheduled fall gives the asynchronous reset a real edge at time zero,
    // so no flop or assertion sees unknown values at the first clock
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    // idle line: rising change, no window yet
    flip(1'b0);
    $display("test lone transition done");
    // falling change at a random point inside the window
    gap = 2 * TICK + $urandom_range(150000);
    repeat (gap) @(posedge core_clk_i);
    flip(1'b1);
    wait_closed();
    $display("test close transition done");
    // after expiry a change gives no close pulse
    repeat (2 * TICK) @(posedge core_clk_i);
    flip(1'b0);
    // tightest legal spacing still counts as close
    repeat (2 * TICK) @(posedge core_clk_i);
    flip(1'b1);
    wait_closed();
    cmp_span(close_count, 2, 2, "close pulses at ratio detector");
    $display("test expiry and spacing done");
    finish_test();
  end

  initial
  begin
    #8000000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
